//--- logic/tmrctl_top.sv
`timescale 1ns/100ps
`include "tmrctl_consts.svh"
module tmrctl_top
	import tmrctl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_clk_pin,
	input wire logic gate_pin,
	input wire logic timer0_overflow,
	input wire logic cmp1_out,
	input wire logic cmp2_out,
	output logic low_power_osc_enable,
	output logic count_tick,
	output logic [15:0] timer_count
);
	////////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0] ctrl_r;
	logic [7:0] gate_r;
	logic go_r;
	logic toggle_r;
	logic [15:0] count_r;
	logic aw_held_r;
	logic w_held_r;
	logic [3:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wstrb0_r;
	tmrctl_rd_t rd_state_r;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, first stage read only by the second
	logic [1:0] ext_meta_r;
	logic [1:0] gate_meta_r;
	logic ext_async_prev_r;
	logic gate_val_r;
	logic gate_val_d_r;
	always_ff @(posedge aclk)
	begin
		ext_meta_r <= {ext_meta_r[0], ext_clk_pin};
		gate_meta_r <= {gate_meta_r[0], gate_pin};
	end

	////////////////////////////////////////////////////////////////////////////
	// field decode
	wire tmrctl_src_t src_w = tmrctl_src_t'(ctrl_r[`TMRCTL_CS_HI:`TMRCTL_CS_LO]);
	wire [1:0] ps_w = ctrl_r[`TMRCTL_PS_HI:`TMRCTL_PS_LO];
	wire on_w = ctrl_r[`TMRCTL_ON_BIT];
	wire sync_off_w = ctrl_r[`TMRCTL_SYNC_BIT];
	wire ge_w = gate_r[`TMRCTL_GE_BIT];
	wire pol_w = gate_r[`TMRCTL_POL_BIT];
	wire tm_w = gate_r[`TMRCTL_TM_BIT];
	wire spm_w = gate_r[`TMRCTL_SPM_BIT];
	wire [1:0] gss_w = gate_r[`TMRCTL_GSS_HI:`TMRCTL_GSS_LO];

	////////////////////////////////////////////////////////////////////////////
	// clock source selection
	logic [1:0] fdiv_r;
	wire instr_tick_w = (fdiv_r == `TMRCTL_FOSC_DIV);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fdiv_r <= 2'h0;
		else
			fdiv_r <= 2'(fdiv_r + 2'h1);
	end

	// the unsynchronised path still needs a same-domain edge; it just skips the extra stage,
	// so it answers one cycle earlier than the resynchronised path
	wire ext_rise_async_w = ext_meta_r[1] && !ext_async_prev_r;
	logic ext_rise_sync_r;
	always_ff @(posedge aclk)
	begin
		ext_async_prev_r <= ext_meta_r[1];
		ext_rise_sync_r <= ext_rise_async_w;
	end
	wire ext_tick_w = sync_off_w ? ext_rise_async_w : ext_rise_sync_r;

	wire src_tick_w = (src_w == TMRCTL_SRC_INSTR) ? instr_tick_w :
		(src_w == TMRCTL_SRC_FOSC) ? 1'b1 :
		(src_w == TMRCTL_SRC_EXT) ? ext_tick_w : 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// prescaler, cleared while the timer is off
	logic pre_tick_w;
	tmrctl_prescale u_prescale
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(!on_w),
		.tick_in(src_tick_w),
		.ratio_sel(ps_w),
		.tick_out(pre_tick_w)
	);

	////////////////////////////////////////////////////////////////////////////
	// gate path: source, polarity, toggle, single pulse
	wire gate_src_w = (gss_w == 2'h0) ? gate_meta_r[1] :
		(gss_w == 2'h1) ? timer0_overflow :
		(gss_w == 2'h2) ? cmp1_out : cmp2_out;
	wire gate_pol_w = gate_src_w ~^ pol_w;
	logic gate_pol_d_r;
	wire gate_rise_w = gate_pol_w && !gate_pol_d_r;
	wire gate_lvl_w = tm_w ? toggle_r : gate_pol_w;
	wire gate_fall_w = gate_val_d_r && !gate_val_r;
	// single pulse holds the gate closed until armed
	wire gate_open_w = spm_w ? (gate_val_r && go_r) : gate_val_r;
	always_ff @(posedge aclk)
	begin
		gate_pol_d_r <= gate_pol_w;
		gate_val_r <= gate_lvl_w;
		gate_val_d_r <= gate_val_r;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !on_w || !tm_w)
			toggle_r <= 1'b0;
		else if (gate_rise_w)
			toggle_r <= !toggle_r;
	end

	////////////////////////////////////////////////////////////////////////////
	// counter
	wire inc_w = on_w && pre_tick_w && (!ge_w || gate_open_w);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_r <= 16'h0000;
		else if (inc_w)
			count_r <= 16'(count_r + 16'h0001);
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_tick <= 1'b0;
			timer_count <= 16'h0000;
			low_power_osc_enable <= 1'b0;
		end
		else
		begin
			count_tick <= inc_w;
			timer_count <= count_r;
			low_power_osc_enable <= ctrl_r[`TMRCTL_OSCEN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order
	wire aw_take_w = s_axi_awvalid && s_axi_awready;
	wire w_take_w = s_axi_wvalid && s_axi_wready;
	wire wr_go_w = aw_held_r && w_held_r && !s_axi_bvalid;
	wire wr_ctrl_w = wr_go_w && wstrb0_r && ({awaddr_r[3:2], 2'h0} == `TMRCTL_OFF_CTRL);
	wire wr_gate_w = wr_go_w && wstrb0_r && ({awaddr_r[3:2], 2'h0} == `TMRCTL_OFF_GATE);
	wire wr_ok_w = ({awaddr_r[3:2], 2'h0} == `TMRCTL_OFF_CTRL) || ({awaddr_r[3:2], 2'h0} == `TMRCTL_OFF_GATE);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r <= 32'h00000000;
			wstrb0_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else
		begin
			s_axi_awready <= !aw_held_r && !aw_take_w && !s_axi_bvalid;
			s_axi_wready <= !w_held_r && !w_take_w && !s_axi_bvalid;
			if (aw_take_w)
			begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (w_take_w)
			begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb0_r <= s_axi_wstrb[0];
			end
			if (wr_go_w)
			begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok_w ? 2'h0 : 2'h2; // unmapped gets SLVERR
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers; ctrl bit 1 and gate bits 3:2 never stored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= `TMRCTL_CTRL_RST;
			gate_r <= `TMRCTL_GATE_RST;
		end
		else
		begin
			if (wr_ctrl_w)
				ctrl_r <= wdata_r[7:0] & `TMRCTL_CTRL_WMASK;
			if (wr_gate_w)
				gate_r <= {wdata_r[7:4], 2'h0, wdata_r[1:0]};
		end
	end

	// single-pulse status: hardware clear on gate fall wins against a simultaneous write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			go_r <= 1'b0;
		else if (!on_w || !spm_w)
			go_r <= 1'b0;
		else if (gate_fall_w && go_r)
			go_r <= 1'b0;
		else if (wr_gate_w)
			go_r <= wdata_r[`TMRCTL_GO_BIT];
	end

	////////////////////////////////////////////////////////////////////////////
	// read channel
	wire [7:0] gate_rd_w = {gate_r[7:4], go_r, gate_val_r, gate_r[1:0]};
	wire [31:0] rd_mux_w = (s_axi_araddr == `TMRCTL_OFF_CTRL) ? {24'h000000, ctrl_r} :
		(s_axi_araddr == `TMRCTL_OFF_GATE) ? {24'h000000, gate_rd_w} :
		(s_axi_araddr == `TMRCTL_OFF_COUNT) ? {16'h0000, count_r} : 32'h00000000;
	wire rd_ok_w = (s_axi_araddr == `TMRCTL_OFF_CTRL) || (s_axi_araddr == `TMRCTL_OFF_GATE) ||
		(s_axi_araddr == `TMRCTL_OFF_COUNT);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_state_r <= TMRCTL_RD_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else
		begin
			unique case (rd_state_r)
				TMRCTL_RD_IDLE:
				begin
					s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
					if (s_axi_arvalid && s_axi_arready)
					begin
						s_axi_rdata <= rd_mux_w;
						s_axi_rresp <= rd_ok_w ? 2'h0 : 2'h2;
						s_axi_rvalid <= 1'b1;
						s_axi_arready <= 1'b0;
						rd_state_r <= TMRCTL_RD_DATA;
					end
				end
				TMRCTL_RD_DATA:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid <= 1'b0;
						s_axi_arready <= 1'b1;
						rd_state_r <= TMRCTL_RD_IDLE;
					end
				end
				default:
					rd_state_r <= TMRCTL_RD_IDLE;
			endcase
		end
	end
endmodule // tmrctl_top

//--- inc/tmrctl_consts.svh
`ifndef TMRCTL_CONSTS_SVH
`define TMRCTL_CONSTS_SVH
`define TMRCTL_OFF_CTRL 4'h0
`define TMRCTL_OFF_GATE 4'h4
`define TMRCTL_OFF_COUNT 4'h8
`define TMRCTL_CTRL_RST 8'h00
`define TMRCTL_GATE_RST 8'h00
`define TMRCTL_CTRL_WMASK 8'hFD
`define TMRCTL_CS_HI 7
`define TMRCTL_CS_LO 6
`define TMRCTL_PS_HI 5
`define TMRCTL_PS_LO 4
`define TMRCTL_OSCEN_BIT 3
`define TMRCTL_SYNC_BIT 2
`define TMRCTL_ON_BIT 0
`define TMRCTL_GE_BIT 7
`define TMRCTL_POL_BIT 6
`define TMRCTL_TM_BIT 5
`define TMRCTL_SPM_BIT 4
`define TMRCTL_GO_BIT 3
`define TMRCTL_VAL_BIT 2
`define TMRCTL_GSS_HI 1
`define TMRCTL_GSS_LO 0
`define TMRCTL_FOSC_DIV 2'h3
`endif

//--- inc/tmrctl_pkg.sv
package tmrctl_pkg;
	typedef enum logic [1:0] {TMRCTL_SRC_INSTR, TMRCTL_SRC_FOSC, TMRCTL_SRC_EXT, TMRCTL_SRC_RSVD} tmrctl_src_t;
	typedef enum logic [1:0] {TMRCTL_RD_IDLE, TMRCTL_RD_DATA} tmrctl_rd_t;
endpackage

//--- logic/tmrctl_prescale.sv
`timescale 1ns/100ps
`include "tmrctl_consts.svh"
// divides a one-cycle tick stream by 1, 2, 4 or 8
module tmrctl_prescale
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic tick_in,
	input wire logic [1:0] ratio_sel,
	output logic tick_out
);
	logic [2:0] cnt_r;
	logic [2:0] last_w;
	// terminal count is ratio minus one
	assign last_w = 3'((4'h1 << ratio_sel) - 4'h1);
	// one output tick per 2**ratio_sel input ticks
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clear)
		begin
			cnt_r <= 3'h0;
			tick_out <= 1'b0;
		end
		else
		begin
			tick_out <= tick_in && (cnt_r >= last_w);
			if (tick_in)
				cnt_r <= (cnt_r >= last_w) ? 3'h0 : 3'(cnt_r + 3'h1);
		end
	end
endmodule // tmrctl_prescale

//--- bench/tmrctl_properties.sv
`timescale 1ns/100ps
module tmrctl_properties
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic count_tick,
	input wire logic [15:0] timer_count
);
	// one domain, reset is synchronous
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////
	// answers stand until the master takes them
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	// no new request while an answer waits
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during answer");
	a_read_answers: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// unmapped places give an error code
	a_wr_unmapped: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 4'hC
		|-> ##[1:4] (s_axi_bvalid && s_axi_bresp == 2'h2)) else $error("unmapped write not refused");
	a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	a_ctrl_bit1: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0
		|=> s_axi_rdata[1] == 1'b0 && s_axi_rdata[31:8] == 24'h0) else $error("control reads bad bits");
	// counter only ever steps by one, and each tick shows in it
	a_count_step: assert property ($changed(timer_count) |-> timer_count == $past(timer_count) + 16'h1)
		else $error("counter jumped");
	a_tick_counts: assert property (count_tick |-> ##[0:2] $changed(timer_count))
		else $error("tick without increment");
	c_tick: cover property (count_tick);
	c_unmapped: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // tmrctl_properties

//--- bench/tmrctl_bench.sv
`timescale 1ns/100ps
module tmrctl_bench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ext_clk_pin, gate_pin, timer0_overflow;
	logic cmp1_out, cmp2_out, low_power_osc_enable, count_tick;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] timer_count;
	int err_count, num_checks;
	tmrctl_top u_tmrctl_top (.*);
	////////////////////////////////////////
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// address and data go out together, each released when taken
	task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		bit aw, w;
		aw = 0;
		w = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			aw = aw | s_axi_awready;
			w = w | s_axi_wready;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		while (!(aw && w));
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'b0;
		chk("bresp", s_axi_bresp, er);
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		chk("rresp", s_axi_rresp, er);
	endtask
	// counts ticks; edges of a config change may add or lose one
	task ticks(input int cyc, input int e);
		int n;
		n = 0;
		repeat (cyc)
		begin
			@(posedge aclk);
			n += (count_tick === 1'b1);
		end
		chk("ticks", n >= e - 1 && n <= e + 1, 1'b1);
	endtask
	////////////////////////////////////////
	task t_regs;
		logic [31:0] d;
		rd(4'h0, d, 2'h0);
		chk("ctrl_rst", d, 32'h0);
		rd(4'h4, d, 2'h0);
		chk("gate_rst", d & 32'hFFFFFFFB, 32'h0);
		chk("osc_rst", low_power_osc_enable, 1'b0);
		wr(4'h0, 8'hFF, 2'h0);
		rd(4'h0, d, 2'h0);
		chk("ctrl_rb", d, 32'hFD);
		chk("osc_on", low_power_osc_enable, 1'b1);
		wr(4'h0, 8'h00, 2'h0);
		repeat (2) @(posedge aclk);
		chk("osc_off", low_power_osc_enable, 1'b0);
		wr(4'hC, 8'h5A, 2'h2);
		rd(4'hC, d, 2'h2);
		chk("unmapped", d, 32'h0);
	endtask
	task t_rate;
		logic [15:0] c;
		for (int i = 0; i < 4; i++)
		begin
			wr(4'h0, 8'h41 | 8'(i << 4), 2'h0);
			repeat (4) @(posedge aclk);
			ticks(64, 64 >> i);
		end
		wr(4'h0, 8'h01, 2'h0);
		repeat (4) @(posedge aclk);
		ticks(64, 16);
		wr(4'h0, 8'h00, 2'h0);
		repeat (3) @(posedge aclk);
		c = timer_count;
		ticks(32, 0);
		chk("count_held", timer_count, c);
	endtask
	task t_gate;
		logic [31:0] d;
		wr(4'h4, 8'hC0, 2'h0);
		wr(4'h0, 8'h41, 2'h0);
		ticks(32, 0);
		gate_pin <= 1'b1;
		repeat (6) @(posedge aclk);
		ticks(32, 32);
		rd(4'h4, d, 2'h0);
		chk("gate_hi", d[2], 1'b1);
		wr(4'h4, 8'h40, 2'h0);
		gate_pin <= 1'b0;
		repeat (6) @(posedge aclk);
		ticks(32, 32);
		rd(4'h4, d, 2'h0);
		chk("gate_lo", d[2], 1'b0);
	endtask
	// external pin source, both sync settings, then single-pulse status set and hardware clear
	task t_ext;
		logic [31:0] d;
		logic [15:0] c;
		for (int s = 0; s < 2; s++)
		begin
			wr(4'h0, 8'h81 | 8'(s << 2), 2'h0);
			repeat (4) @(posedge aclk);
			c = timer_count;
			repeat (8)
			begin
				ext_clk_pin <= 1'b1;
				repeat (2) @(posedge aclk);
				ext_clk_pin <= 1'b0;
				repeat (2) @(posedge aclk);
			end
			repeat (6) @(posedge aclk);
			chk("ext_count", 16'(timer_count - c), 16'h0008);
		end
		wr(4'h0, 8'h41, 2'h0);
		wr(4'h4, 8'h10, 2'h0);
		wr(4'h4, 8'h18, 2'h0);
		rd(4'h4, d, 2'h0);
		chk("go_set", d[3], 1'b1);
		gate_pin <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(4'h4, d, 2'h0);
		chk("go_clr", d[3], 1'b0);
		gate_pin <= 1'b0;
	endtask
	task summarize;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial
	begin
		aclk = 0;
		forever #12.5 aclk = ~aclk;
	end
	// hang guard, far beyond the few hundred cycles needed
	initial
	begin
		repeat (5000) @(posedge aclk);
		err_count++;
		summarize;
	end
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{ext_clk_pin, gate_pin, timer0_overflow, cmp1_out, cmp2_out} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		s_axi_wstrb = 4'hF;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_regs;
		t_rate;
		t_gate;
		t_ext;
		summarize;
	end
endmodule // tmrctl_bench
bind tmrctl_top tmrctl_properties u_tmrctl_properties (.*);
